// ==== rtl/partial_product_gate.sv ====
`timescale 1ns/1ps
module partial_product_gate (
  // multiplier operand bits
  input  wire logic operand_a_i,
  input  wire logic operand_b_i,
  // partial product into the carry generate path
  output logic      product_o
);

  assign product_o = operand_a_i & operand_b_i;

endmodule : partial_product_gate

// ==== rtl/slice_storage_elements.sv ====
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module slice_storage_elements (
  // clock and reset
  input  wire logic                                  core_clk_i,
  input  wire logic                                  rst_n_i,
  // register port
  input  wire logic [slice_storage_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [slice_storage_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                                  reg_wr_i,
  input  wire logic                                  reg_rd_i,
  output logic      [slice_storage_pkg::DATA_W-1:0]  reg_rdata_o,
  // shared slice controls
  input  wire logic                                  slice_clk_i,
  input  wire logic                                  clk_en_i,
  input  wire logic                                  slice_force_in_i,
  input  wire logic                                  opposite_force_in_i,
  input  wire logic                                  global_init_i,
  // upper half data
  input  wire logic                                  upper_func_i,
  input  wire logic                                  upper_bypass_in_i,
  output logic                                       upper_q_o,
  // lower half data
  input  wire logic                                  lower_func_i,
  input  wire logic                                  lower_bypass_in_i,
  output logic                                       lower_q_o,
  // partial product operands and carry
  input  wire logic                                  lower_op_a_i,
  input  wire logic                                  lower_op_b_i,
  input  wire logic                                  upper_op_a_i,
  input  wire logic                                  upper_op_b_i,
  input  wire logic                                  lower_carry_sel_i,
  input  wire logic                                  upper_carry_sel_i,
  input  wire logic                                  carry_in_i,
  output logic                                       lower_carry_o,
  output logic                                       carry_out_o
);

  logic [slice_storage_pkg::CFG_W-1:0]  cfg_reg;
  logic [slice_storage_pkg::DATA_W-1:0] rdata_reg;
  logic                                 clk_lvl_reg;

  logic latch_mode;
  logic async_mode;
  logic force_high;
  logic clk_lvl;
  logic ce_lvl;
  logic force_lvl;
  logic opposite_lvl;
  logic clk_rise;
  logic cell_set;
  logic cell_clr;
  logic upper_d;
  logic lower_d;
  logic upper_init;
  logic lower_init;
  logic init_load;
  logic upper_q;
  logic lower_q;
  logic lower_product;
  logic upper_product;
  logic lower_carry;
  logic [slice_storage_pkg::DATA_W-1:0] status_word;

  // configuration fields
  assign latch_mode = cfg_reg[slice_storage_pkg::CFG_LATCH_MODE];
  assign async_mode = cfg_reg[slice_storage_pkg::CFG_ASYNC_MODE];
  assign force_high = cfg_reg[slice_storage_pkg::CFG_FORCE_HIGH];

  // polarity selection on the clock, enable and both force inputs; global init has none
  assign clk_lvl      = slice_clk_i ^ cfg_reg[slice_storage_pkg::CFG_CLK_INV];
  assign ce_lvl       = clk_en_i ^ cfg_reg[slice_storage_pkg::CFG_CE_INV];
  assign force_lvl    = slice_force_in_i ^ cfg_reg[slice_storage_pkg::CFG_FORCE_INV];
  assign opposite_lvl = opposite_force_in_i ^ cfg_reg[slice_storage_pkg::CFG_OPPOSITE_INV];

  // the slice clock is a sampled fabric level; edges come from its history
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      clk_lvl_reg <= 1'b0;
    end else begin
      clk_lvl_reg <= clk_lvl;
    end
  end

  assign clk_rise = clk_lvl & ~clk_lvl_reg;

  // one force input and its opposite, both follow the single sync/async mode
  assign cell_set = force_high ? force_lvl : opposite_lvl;
  assign cell_clr = force_high ? opposite_lvl : force_lvl;

  // fixed data selectors
  assign upper_d = cfg_reg[slice_storage_pkg::CFG_UPPER_BYPASS] ?
                   upper_bypass_in_i : upper_func_i;
  assign lower_d = cfg_reg[slice_storage_pkg::CFG_LOWER_BYPASS] ?
                   lower_bypass_in_i : lower_func_i;

  // start value defaults to the force value unless overridden
  assign upper_init = cfg_reg[slice_storage_pkg::CFG_INIT_OVERRIDE] ?
                      cfg_reg[slice_storage_pkg::CFG_UPPER_INIT] : force_high;
  assign lower_init = cfg_reg[slice_storage_pkg::CFG_INIT_OVERRIDE] ?
                      cfg_reg[slice_storage_pkg::CFG_LOWER_INIT] : force_high;
  assign init_load  = global_init_i;

  // both cells see the same clock, enable and force signals
  storage_cell upper_storage_cell (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .latch_mode_i (latch_mode),
    .async_mode_i (async_mode),
    .init_value_i (upper_init),
    .init_load_i  (init_load),
    .edge_i       (clk_rise),
    .gate_i       (clk_lvl),
    .enable_i     (ce_lvl),
    .set_i        (cell_set),
    .clr_i        (cell_clr),
    .d_i          (upper_d),
    .q_o          (upper_q)
  );

  storage_cell lower_storage_cell (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .latch_mode_i (latch_mode),
    .async_mode_i (async_mode),
    .init_value_i (lower_init),
    .init_load_i  (init_load),
    .edge_i       (clk_rise),
    .gate_i       (clk_lvl),
    .enable_i     (ce_lvl),
    .set_i        (cell_set),
    .clr_i        (cell_clr),
    .d_i          (lower_d),
    .q_o          (lower_q)
  );

  assign upper_q_o = upper_q;
  assign lower_q_o = lower_q;

  // partial products duplicate one multiplier term outside the function table
  partial_product_gate lower_product_and (
    .operand_a_i (lower_op_a_i),
    .operand_b_i (lower_op_b_i),
    .product_o   (lower_product)
  );

  partial_product_gate upper_product_and (
    .operand_a_i (upper_op_a_i),
    .operand_b_i (upper_op_b_i),
    .product_o   (upper_product)
  );

  // carry select: propagate incoming carry or generate from the product
  assign lower_carry   = lower_carry_sel_i ? carry_in_i : lower_product;
  assign lower_carry_o = lower_carry;
  assign carry_out_o   = upper_carry_sel_i ? lower_carry : upper_product;

  // configuration register; a write takes effect on the next cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_reg <= slice_storage_pkg::CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == slice_storage_pkg::CFG_OFFSET) begin
      cfg_reg <= reg_wdata_i[slice_storage_pkg::CFG_W-1:0];
    end
  end

  always_comb begin
    status_word = '0;
    status_word[slice_storage_pkg::STAT_LOWER_Q] = lower_q;
    status_word[slice_storage_pkg::STAT_UPPER_Q] = upper_q;
    status_word[slice_storage_pkg::STAT_CLK_LVL] = clk_lvl_reg;
    status_word[slice_storage_pkg::STAT_LATCH]   = latch_mode;
    status_word[slice_storage_pkg::STAT_ASYNC]   = async_mode;
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        slice_storage_pkg::CFG_OFFSET: begin
          rdata_reg <= {{(slice_storage_pkg::DATA_W-slice_storage_pkg::CFG_W){1'b0}},
                        cfg_reg};
        end
        slice_storage_pkg::STATUS_OFFSET: begin
          rdata_reg <= status_word;
        end
        default: begin
          rdata_reg <= '0;
        end
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata_o = rdata_reg;

endmodule : slice_storage_elements

// ==== rtl/slice_storage_pkg.sv ====
package slice_storage_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] CFG_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int         ADDR_W        = 8;
  localparam int         DATA_W        = 32;

  // configuration register field positions
  localparam int CFG_LATCH_MODE    = 0;
  localparam int CFG_ASYNC_MODE    = 1;
  localparam int CFG_UPPER_BYPASS  = 2;
  localparam int CFG_LOWER_BYPASS  = 3;
  localparam int CFG_FORCE_HIGH    = 4;
  localparam int CFG_CLK_INV       = 5;
  localparam int CFG_CE_INV        = 6;
  localparam int CFG_FORCE_INV     = 7;
  localparam int CFG_OPPOSITE_INV  = 8;
  localparam int CFG_UPPER_INIT    = 9;
  localparam int CFG_LOWER_INIT    = 10;
  localparam int CFG_INIT_OVERRIDE = 11;
  localparam int CFG_W             = 12;

  // all controls active high, flip-flop mode, sync force to zero
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;

  // status register field positions
  localparam int STAT_LOWER_Q  = 0;
  localparam int STAT_UPPER_Q  = 1;
  localparam int STAT_CLK_LVL  = 2;
  localparam int STAT_LATCH    = 3;
  localparam int STAT_ASYNC    = 4;

  // storage cell value after reset
  localparam logic CELL_RESET_Q = 1'b0;

endpackage : slice_storage_pkg

// ==== rtl/storage_cell.sv ====
`timescale 1ns/1ps
module storage_cell (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // configuration
  input  wire logic latch_mode_i,
  input  wire logic async_mode_i,
  input  wire logic init_value_i,
  input  wire logic init_load_i,
  // shared controls, polarity already resolved
  input  wire logic edge_i,
  input  wire logic gate_i,
  input  wire logic enable_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  // data
  input  wire logic d_i,
  output logic      q_o
);

  logic q_reg;
  logic imm_clr;
  logic imm_set;
  logic q_now;

  // latch mode and async mode act without waiting for an edge
  assign imm_clr = clr_i & (async_mode_i | latch_mode_i);
  assign imm_set = set_i & (async_mode_i | latch_mode_i);

  always_comb begin
    if (imm_clr) begin
      q_now = 1'b0;
    end else if (imm_set) begin
      q_now = 1'b1;
    end else if (latch_mode_i && gate_i && enable_i) begin
      q_now = d_i;
    end else begin
      q_now = q_reg;
    end
  end

  // latch output is combinational, so it moves in the same cycle
  assign q_o = q_now;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || init_load_i) begin
      q_reg <= init_value_i;
    end else if (latch_mode_i) begin
      q_reg <= q_now;
    end else if (clr_i && (async_mode_i || edge_i)) begin
      q_reg <= 1'b0;
    end else if (set_i && (async_mode_i || edge_i)) begin
      q_reg <= 1'b1;
    end else if (edge_i && enable_i) begin
      q_reg <= d_i;
    end
  end

endmodule : storage_cell

// ==== sim/fabric_clock_model.sv ====
`timescale 1ns/1ps
module fabric_clock_model (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // pulse request
  input  wire logic go_i,
  // slice clock towards the cells
  output logic      slice_clk_o
);
  // the slice clock stands still between requests, so only asked-for edges occur
  logic [1:0] cnt_reg;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i)
      cnt_reg <= 2'h0;
    else if (go_i)
      cnt_reg <= 2'h3;
    else if (cnt_reg != 2'h0)
      cnt_reg <= cnt_reg - 2'h1;
  end
  assign slice_clk_o = (cnt_reg != 2'h0);
endmodule : fabric_clock_model

// ==== sim/slice_storage_properties.sv ====
`timescale 1ns/1ps
module slice_storage_properties (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  // register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // slice controls and data
  input wire logic        slice_clk_i,
  input wire logic        clk_en_i,
  input wire logic        slice_force_in_i,
  input wire logic        opposite_force_in_i,
  input wire logic        global_init_i,
  input wire logic        upper_func_i,
  input wire logic        upper_bypass_in_i,
  input wire logic        lower_func_i,
  input wire logic        lower_bypass_in_i,
  // cell outputs
  input wire logic        upper_q_o,
  input wire logic        lower_q_o
);
  // config mirrored from bus writes, as the checker cannot see the register
  logic [11:0] cfg_reg;
  logic        clk_eff, d_up, d_lo, clr_act, set_act, imm, rd_cfg, rd_stat;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i)
      cfg_reg <= 12'h000;
    else if (reg_wr_i && reg_addr_i == slice_storage_pkg::CFG_OFFSET)
      cfg_reg <= reg_wdata_i[11:0];
  end
  assign rd_cfg  = reg_rd_i && reg_addr_i == slice_storage_pkg::CFG_OFFSET;
  assign rd_stat = reg_rd_i && reg_addr_i == slice_storage_pkg::STATUS_OFFSET;
  assign clk_eff = slice_clk_i ^ cfg_reg[5];
  assign d_up    = cfg_reg[2] ? upper_bypass_in_i : upper_func_i;
  assign d_lo    = cfg_reg[3] ? lower_bypass_in_i : lower_func_i;
  assign clr_act = cfg_reg[4] ? opposite_force_in_i ^ cfg_reg[8] : slice_force_in_i ^ cfg_reg[7];
  assign set_act = cfg_reg[4] ? slice_force_in_i ^ cfg_reg[7] : opposite_force_in_i ^ cfg_reg[8];
  assign imm     = cfg_reg[0] | cfg_reg[1];
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside slot");
  a_cfg_readback: assert property (
    $past(rd_cfg) |-> reg_rdata_o == {20'h0, $past(cfg_reg)}) else $error("config readback");
  a_unmapped_zero: assert property ($past(reg_rd_i && !rd_cfg && !rd_stat)
    |-> reg_rdata_o == 32'h0) else $error("unmapped read");
  a_status_read: assert property (
    $past(rd_stat) |-> reg_rdata_o[4:3] == $past(cfg_reg[1:0])
    && ($past(imm) || reg_rdata_o[1:0] == $past({upper_q_o, lower_q_o})))
    else $error("status read");
  a_clear_wins: assert property (
    imm && clr_act && !global_init_i |-> !upper_q_o && !lower_q_o) else $error("clear");
  a_set_force: assert property (
    imm && set_act && !clr_act && !global_init_i |-> upper_q_o && lower_q_o)
    else $error("set");
  a_ff_capture: assert property (
    !imm && clk_eff && !$past(clk_eff) && (clk_en_i ^ cfg_reg[6]) && !clr_act && !set_act
    && !global_init_i |-> ##2 {upper_q_o, lower_q_o} == $past({d_up, d_lo}, 2))
    else $error("capture");
  a_ff_hold: assert property (
    !imm && !clk_eff && !$past(clk_eff) && !$past(clk_eff, 2) && !global_init_i
    && !$past(global_init_i) && !$past(reg_wr_i) && !$past(reg_wr_i, 2)
    |-> $stable(upper_q_o) && $stable(lower_q_o)) else $error("hold");
endmodule : slice_storage_properties
bind slice_storage_elements slice_storage_properties u_props (.*);

// ==== sim/tb_slice_storage_elements.sv ====
`timescale 1ns/1ps
module tb_slice_storage_elements;
  logic        core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, go_i, slice_clk_i;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic        clk_en_i, slice_force_in_i, opposite_force_in_i, global_init_i;
  logic        upper_func_i, upper_bypass_in_i, lower_func_i, lower_bypass_in_i;
  logic        lower_op_a_i, lower_op_b_i, upper_op_a_i, upper_op_b_i, carry_in_i;
  logic        lower_carry_sel_i, upper_carry_sel_i;
  logic        upper_q_o, lower_q_o, lower_carry_o, carry_out_o;
  int          n_mismatch, n_compared;
  slice_storage_elements DUT (.*);
  fabric_clock_model u_fabric (.core_clk_i, .rst_n_i, .go_i, .slice_clk_o(slice_clk_i));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chq(input logic [1:0] e);
    chk({30'h0, upper_q_o, lower_q_o}, {30'h0, e});
  endtask : chq
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask : rd
  // bits: enable, force, opposite, upper func, upper bypass, lower func, lower bypass
  task automatic drv(input logic [6:0] v);
    @(posedge core_clk_i);
    {clk_en_i, slice_force_in_i, opposite_force_in_i, upper_func_i, upper_bypass_in_i,
     lower_func_i, lower_bypass_in_i} <= v;
    #1;
  endtask : drv
  task automatic pulse();
    @(posedge core_clk_i);
    go_i <= 1'b1;
    @(posedge core_clk_i);
    go_i <= 1'b0;
    cyc(5);
    #1;
  endtask : pulse
  task automatic ini();
    @(posedge core_clk_i);
    global_init_i <= 1'b1;
    @(posedge core_clk_i);
    global_init_i <= 1'b0;
    cyc(1);
    #1;
  endtask : ini
  task automatic t_regs();
    rd(8'h00, 32'h0);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h0000_0fff);
    wr(8'h04, 32'h1f);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0);
  endtask : t_regs
  task automatic t_carry();
    logic lc;
    logic uc;
    for (int i = 0; i < 128; i++) begin
      @(posedge core_clk_i);
      {lower_op_a_i, lower_op_b_i, lower_carry_sel_i, carry_in_i, upper_op_a_i,
       upper_op_b_i, upper_carry_sel_i} <= i[6:0];
      #1;
      lc = lower_carry_sel_i ? carry_in_i : lower_op_a_i & lower_op_b_i;
      chk({31'h0, lower_carry_o}, {31'h0, lc});
      uc = upper_carry_sel_i ? lc : upper_op_a_i & upper_op_b_i;
      chk({31'h0, carry_out_o}, {31'h0, uc});
    end
  endtask : t_carry
  task automatic t_ff();
    wr(8'h00, 32'h004);
    drv(7'b1000110);
    pulse();
    chq(2'b11);
    drv(7'b0000000);
    pulse();
    chq(2'b11);
    // inverted clock and enable: capture on the falling slice clock with enable low
    wr(8'h00, 32'h060);
    drv(7'b0000010);
    pulse();
    chq(2'b01);
    wr(8'h00, 32'h008);
    drv(7'b1001000);
    pulse();
    chq(2'b10);
  endtask : t_ff
  task automatic t_force();
    wr(8'h00, 32'h010);
    drv(7'b0100000);
    chq(2'b10);
    pulse();
    chq(2'b11);
    drv(7'b0110000);
    pulse();
    chq(2'b00);
    drv(7'b0100000);
    pulse();
    drv(7'b0010000);
    pulse();
    chq(2'b00);
  endtask : t_force
  task automatic t_async();
    drv(7'b0000000);
    wr(8'h00, 32'h012);
    drv(7'b0100000);
    chq(2'b11);
    drv(7'b0110000);
    chq(2'b00);
    wr(8'h00, 32'h082);
    chq(2'b11);
    drv(7'b0010000);
    chq(2'b00);
  endtask : t_async
  task automatic t_latch();
    drv(7'b0100000);
    wr(8'h00, 32'h001);
    drv(7'b1001010);
    pulse();
    chq(2'b11);
    drv(7'b1000000);
    cyc(3);
    chq(2'b11);
    drv(7'b0000000);
    pulse();
    chq(2'b11);
    drv(7'b1000000);
    pulse();
    chq(2'b00);
    wr(8'h00, 32'h011);
    drv(7'b0100000);
    chq(2'b11);
  endtask : t_latch
  task automatic t_init();
    drv(7'b0000000);
    wr(8'h00, 32'ha00);
    ini();
    chq(2'b10);
    rd(8'h04, 32'h2);
    wr(8'h00, 32'h010);
    ini();
    chq(2'b11);
    wr(8'h00, 32'h000);
    ini();
    chq(2'b00);
  endtask : t_init
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // the whole sequence needs under a thousand cycles; five thousand means a hang
  initial begin
    #50000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, go_i, reg_addr_i, reg_wdata_i, global_init_i} = '0;
    {clk_en_i, slice_force_in_i, opposite_force_in_i, upper_func_i, upper_bypass_in_i} = '0;
    {lower_func_i, lower_bypass_in_i, lower_op_a_i, lower_op_b_i, upper_op_a_i} = '0;
    {upper_op_b_i, lower_carry_sel_i, upper_carry_sel_i, carry_in_i} = '0;
    cyc(2);
    rst_n_i <= 1'b1;
    t_regs();
    t_carry();
    t_ff();
    t_force();
    t_async();
    t_latch();
    t_init();
    final_report();
  end
endmodule : tb_slice_storage_elements
